// ---- sensor_regs_cfg.svh ----
`ifndef SENSOR_REGS_CFG_SVH
`define SENSOR_REGS_CFG_SVH

`define OFS_CHIP_ID_LOW_REVISION  8'h00
`define OFS_CHIP_ID_HIGH          8'h01
`define OFS_UPDATE_PENDING_STATUS 8'h02
`define OFS_EXPOSURE_FORMAT_SETUP 8'h10
`define OFS_READOUT_TIMING_SETUP  8'h11
`define OFS_EXPOSURE_STEP_SETUP   8'h13
`define OFS_STROBE_CLOCK_PIN_SETUP 8'h14

`define RST_EXPOSURE_FORMAT_SETUP  8'h27
`define RST_READOUT_TIMING_SETUP   8'h70
// Step field must come up as 1/16
`define RST_EXPOSURE_STEP_SETUP    8'h2f
`define RST_STROBE_CLOCK_PIN_SETUP 8'h00

`define BIT_EXPOSURE_PENDING 0
`define BIT_GAIN_PENDING     2
`define BIT_AUTO_EXPOSURE    0
`define BIT_AUTO_GAIN        2
`define BIT_FOUR_WIRE        5
`define BIT_EXTRA_BLACK      0
`define BIT_COLUMN_SHUFFLE   2
`define BIT_SIXTY_HZ         6
`define POS_STEP_LO          5
`define POS_STEP_HI          6
`define POS_PIN_ROUTE_LO     0
`define POS_PIN_ROUTE_HI     1
`define POS_QUAL_MODE_LO     2
`define POS_QUAL_MODE_HI     3
`define POS_STROBE_MODE_LO   6
`define POS_STROBE_MODE_HI   7

`endif

// ---- sensor_regs_pkg.sv ----
package sensor_regs_pkg;

	typedef enum logic [1:0] {
		QUAL_OFF       = 2'b00,
		QUAL_FREE      = 2'b01,
		QUAL_LINE      = 2'b10,
		QUAL_DATA_ONLY = 2'b11
	} qual_mode_t;

	typedef enum logic [1:0] {
		STROBE_OFF        = 2'b00,
		STROBE_STATUS     = 2'b01,
		STROBE_SYNC_OUT   = 2'b10,
		STROBE_COMPARATOR = 2'b11
	} strobe_mode_t;

	typedef enum logic [1:0] {
		ROUTE_STROBE_A = 2'b00,
		ROUTE_STROBE_B = 2'b01,
		ROUTE_QUAL     = 2'b10,
		ROUTE_QUAL_INV = 2'b11
	} pin_route_t;

	typedef enum logic [1:0] {
		STEP_1_8  = 2'b00,
		STEP_1_16 = 2'b01,
		STEP_1_32 = 2'b10,
		STEP_1_64 = 2'b11
	} exposure_step_t;

endpackage : sensor_regs_pkg

// ---- pin_function_if.sv ----
`timescale 1ns/1ps
interface pin_function_if;
	import sensor_regs_pkg::*;
	pin_route_t pinRoute;
	qual_mode_t   qualMode;
	strobe_mode_t strobeMode;
	modport setup (output pinRoute, output qualMode, output strobeMode);
	modport pins  (input pinRoute, input qualMode, input strobeMode);
endinterface : pin_function_if

// ---- pin_function_select.sv ----
`timescale 1ns/1ps
module pin_function_select
	import sensor_regs_pkg::*;
(
	input  wire logic    sys_clk,
	input  wire logic    reset,
	pin_function_if.pins cfg,
	input  wire logic    controlPeriod,
	input  wire logic    dataPeriod,
	input  wire logic    statusLineVisible,
	input  wire logic    syncOutPulse,
	input  wire logic    converterComparatorOut,
	output logic         qualifyingClock,
	output logic         frameStrobe
);
	// Free-running qualifying clock: half the system rate
	logic freeClock;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			freeClock <= 1'b0;
		end else begin
			freeClock <= ~freeClock;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			qualifyingClock <= 1'b0;
		end else begin
			unique case (cfg.qualMode)
				QUAL_OFF:       qualifyingClock <= 1'b0;
				QUAL_FREE:      qualifyingClock <= ~freeClock;
				QUAL_LINE:      qualifyingClock <= ~freeClock & (controlPeriod | dataPeriod);
				QUAL_DATA_ONLY: qualifyingClock <= ~freeClock & dataPeriod;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			frameStrobe <= 1'b0;
		end else begin
			unique case (cfg.pinRoute)
				ROUTE_QUAL:     frameStrobe <= ~freeClock;
				ROUTE_QUAL_INV: frameStrobe <= freeClock;
				default: begin
					unique case (cfg.strobeMode)
						STROBE_OFF:        frameStrobe <= 1'b0;
						STROBE_STATUS:     frameStrobe <= statusLineVisible;
						STROBE_SYNC_OUT:   frameStrobe <= syncOutPulse;
						STROBE_COMPARATOR: frameStrobe <= converterComparatorOut;
					endcase
				end
			endcase
		end
	end
endmodule : pin_function_select

// ---- sensor_status_setup_registers.sv ----
`timescale 1ns/1ps
`include "sensor_regs_cfg.svh"
module sensor_status_setup_registers
	import sensor_regs_pkg::*;
#(
	// Arbitrary identification values, not those of any real part
	parameter logic [11:0] CHIP_TYPE     = 12'h5a3,
	parameter logic [3:0]  MASK_REVISION = 4'h2
)
(
	input  wire logic     sys_clk,
	input  wire logic     reset,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWriteData,
	input  wire logic     regWrite,
	output logic [7:0]    regReadData,
	input  wire logic     exposureWritten,
	input  wire logic     gainWritten,
	input  wire logic     exposureConsumed,
	input  wire logic     gainConsumed,
	input  wire logic     controlPeriod,
	input  wire logic     dataPeriod,
	input  wire logic     statusLineVisible,
	input  wire logic     syncOutPulse,
	input  wire logic     converterComparatorOut,
	output logic          autoExposureEnable,
	output logic          autoGainEnable,
	output logic          busWidthFour,
	output logic          extraBlackLines,
	output logic          columnShuffle,
	output logic          sixtyHzTiming,
	output exposure_step_t exposureStep,
	output logic          qualifyingClock,
	output logic          frameStrobe
);
	logic [7:0] exposureFormatSetup;
	logic [7:0] readoutTimingSetup;
	logic [7:0] exposureStepSetup;
	logic [7:0] strobeClockPinSetup;
	logic       exposurePending;
	logic       gainPending;
	logic [7:0] next_readData;

	pin_function_if pinCfg ();

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = regWrite && (addr == ofs);
	endfunction : hit

	// Only setup offsets decode a write; ID and status have no write path
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			exposureFormatSetup <= `RST_EXPOSURE_FORMAT_SETUP;
		end else if (hit(regAddr, `OFS_EXPOSURE_FORMAT_SETUP)) begin
			exposureFormatSetup <= regWriteData;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			readoutTimingSetup <= `RST_READOUT_TIMING_SETUP;
		end else if (hit(regAddr, `OFS_READOUT_TIMING_SETUP)) begin
			readoutTimingSetup <= regWriteData;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			exposureStepSetup <= `RST_EXPOSURE_STEP_SETUP;
		end else if (hit(regAddr, `OFS_EXPOSURE_STEP_SETUP)) begin
			exposureStepSetup <= regWriteData;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			strobeClockPinSetup <= `RST_STROBE_CLOCK_PIN_SETUP;
		end else if (hit(regAddr, `OFS_STROBE_CLOCK_PIN_SETUP)) begin
			strobeClockPinSetup <= regWriteData;
		end
	end

	// A new write in the consume cycle keeps the flag set
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			exposurePending <= 1'b0;
		end else if (exposureWritten) begin
			exposurePending <= 1'b1;
		end else if (exposureConsumed) begin
			exposurePending <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			gainPending <= 1'b0;
		end else if (gainWritten) begin
			gainPending <= 1'b1;
		end else if (gainConsumed) begin
			gainPending <= 1'b0;
		end
	end

	always_comb begin
		next_readData = 8'h00;
		unique case (regAddr)
			`OFS_CHIP_ID_LOW_REVISION:   next_readData = {CHIP_TYPE[3:0], MASK_REVISION};
			`OFS_CHIP_ID_HIGH:           next_readData = CHIP_TYPE[11:4];
			`OFS_UPDATE_PENDING_STATUS: begin
				next_readData[`BIT_EXPOSURE_PENDING] = exposurePending;
				next_readData[`BIT_GAIN_PENDING]     = gainPending;
			end
			`OFS_EXPOSURE_FORMAT_SETUP:  next_readData = exposureFormatSetup;
			`OFS_READOUT_TIMING_SETUP:   next_readData = readoutTimingSetup;
			`OFS_EXPOSURE_STEP_SETUP:    next_readData = exposureStepSetup;
			`OFS_STROBE_CLOCK_PIN_SETUP: next_readData = strobeClockPinSetup;
			default:                     next_readData = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			regReadData <= 8'h00;
		end else begin
			regReadData <= next_readData;
		end
	end

	// Controller holds its current value while these enables are low
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			autoExposureEnable <= 1'b1;
			autoGainEnable     <= 1'b1;
			busWidthFour       <= 1'b1;
			extraBlackLines    <= 1'b0;
			columnShuffle      <= 1'b0;
			sixtyHzTiming      <= 1'b1;
			exposureStep       <= STEP_1_16;
		end else begin
			autoExposureEnable <= exposureFormatSetup[`BIT_AUTO_EXPOSURE];
			autoGainEnable     <= exposureFormatSetup[`BIT_AUTO_GAIN];
			busWidthFour       <= exposureFormatSetup[`BIT_FOUR_WIRE];
			// Separate bits so border lines and shuffle never interact
			extraBlackLines    <= readoutTimingSetup[`BIT_EXTRA_BLACK];
			columnShuffle      <= readoutTimingSetup[`BIT_COLUMN_SHUFFLE];
			sixtyHzTiming      <= readoutTimingSetup[`BIT_SIXTY_HZ];
			exposureStep       <= exposure_step_t'(exposureStepSetup[`POS_STEP_HI:`POS_STEP_LO]);
		end
	end

	assign pinCfg.pinRoute = pin_route_t'(strobeClockPinSetup[`POS_PIN_ROUTE_HI:`POS_PIN_ROUTE_LO]);
	assign pinCfg.qualMode   = qual_mode_t'(strobeClockPinSetup[`POS_QUAL_MODE_HI:`POS_QUAL_MODE_LO]);
	assign pinCfg.strobeMode = strobe_mode_t'(
		strobeClockPinSetup[`POS_STROBE_MODE_HI:`POS_STROBE_MODE_LO]);

	pin_function_select pinMux (
		.sys_clk               (sys_clk),
		.reset                 (reset),
		.cfg                   (pinCfg.pins),
		.controlPeriod         (controlPeriod),
		.dataPeriod            (dataPeriod),
		.statusLineVisible     (statusLineVisible),
		.syncOutPulse          (syncOutPulse),
		.converterComparatorOut(converterComparatorOut),
		.qualifyingClock       (qualifyingClock),
		.frameStrobe           (frameStrobe)
	);
endmodule : sensor_status_setup_registers

// ---- sensor_status_setup_registers_properties.sv ----
`timescale 1ns/1ps
module sensor_regs_checker
	import sensor_regs_pkg::*;
#(
	parameter logic [11:0] CHIP_TYPE     = 12'h5a3,
	parameter logic [3:0]  MASK_REVISION = 4'h2
)
(
	input wire logic       sys_clk,
	input wire logic       reset,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWriteData,
	input wire logic       regWrite,
	input wire logic [7:0] regReadData,
	input wire logic       exposureWritten,
	input wire logic       gainWritten,
	input wire logic       converterComparatorOut,
	input wire logic       autoExposureEnable,
	input wire logic       autoGainEnable,
	input wire logic       busWidthFour,
	input wire logic       extraBlackLines,
	input wire logic       columnShuffle,
	input wire logic       sixtyHzTiming,
	input exposure_step_t  exposureStep,
	input wire logic       qualifyingClock,
	input wire logic       frameStrobe
);
	logic [7:0] pinSel;
	// Pin setup byte mirrored here, the checker cannot see the register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			pinSel <= 8'h00;
		else if (regWrite && regAddr == 8'h14)
			pinSel <= regWriteData;
	end
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_idlo; regAddr == 8'h00 |=> regReadData == {CHIP_TYPE[3:0], MASK_REVISION}; endproperty
	a_idlo: assert property (p_idlo) else $error("id low wrong");
	property p_idhi; regAddr == 8'h01 |=> regReadData == CHIP_TYPE[11:4]; endproperty
	a_idhi: assert property (p_idhi) else $error("id high wrong");
	property p_expset; exposureWritten && regAddr == 8'h02 ##1 regAddr == 8'h02 |=> regReadData[0]; endproperty
	a_expset: assert property (p_expset) else $error("exposure flag missing");
	property p_gainset; gainWritten && regAddr == 8'h02 ##1 regAddr == 8'h02 |=> regReadData[2]; endproperty
	a_gainset: assert property (p_gainset) else $error("gain flag missing");
	property p_fmt; regWrite && regAddr == 8'h10 |-> ##2 {busWidthFour, autoGainEnable,
		autoExposureEnable} == {$past(regWriteData[5], 2), $past(regWriteData[2], 2),
		$past(regWriteData[0], 2)}; endproperty
	a_fmt: assert property (p_fmt) else $error("format outputs wrong");
	property p_readout; regWrite && regAddr == 8'h11 |-> ##2 {sixtyHzTiming, columnShuffle,
		extraBlackLines} == {$past(regWriteData[6], 2), $past(regWriteData[2], 2),
		$past(regWriteData[0], 2)}; endproperty
	a_readout: assert property (p_readout) else $error("readout outputs wrong");
	property p_step; regWrite && regAddr == 8'h13 |-> ##2 exposureStep == $past(regWriteData[6:5], 2); endproperty
	a_step: assert property (p_step) else $error("step size wrong");
	property p_qoff; (pinSel[3:2] == 2'b00) [*3] |-> !qualifyingClock; endproperty
	a_qoff: assert property (p_qoff) else $error("clock pin not off");
	property p_qfree; (pinSel[3:2] == 2'b01) [*3] |-> qualifyingClock != $past(qualifyingClock); endproperty
	a_qfree: assert property (p_qfree) else $error("clock pin not free");
	property p_routed; (pinSel[1] && $stable(pinSel)) [*3] |-> frameStrobe != $past(frameStrobe); endproperty
	a_routed: assert property (p_routed) else $error("strobe not clock");
	property p_cmp; (pinSel[7:6] == 2'b11 && !pinSel[1]) [*3] |-> frameStrobe == $past(converterComparatorOut); endproperty
	a_cmp: assert property (p_cmp) else $error("strobe not comparator");
endmodule : sensor_regs_checker
bind sensor_status_setup_registers sensor_regs_checker #(.CHIP_TYPE(CHIP_TYPE),
	.MASK_REVISION(MASK_REVISION)) chk (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr),
	.regWriteData(regWriteData), .regWrite(regWrite), .regReadData(regReadData),
	.exposureWritten(exposureWritten), .gainWritten(gainWritten),
	.converterComparatorOut(converterComparatorOut), .autoExposureEnable(autoExposureEnable),
	.autoGainEnable(autoGainEnable), .busWidthFour(busWidthFour),
	.extraBlackLines(extraBlackLines), .columnShuffle(columnShuffle),
	.sixtyHzTiming(sixtyHzTiming), .exposureStep(exposureStep),
	.qualifyingClock(qualifyingClock), .frameStrobe(frameStrobe));

// ---- host_model.sv ----
`timescale 1ns/1ps
module host_model (
	input  wire logic       sys_clk,
	output logic [7:0]      regAddr,
	output logic [7:0]      regWriteData,
	output logic            regWrite,
	input  wire logic [7:0] regReadData
);
	initial begin
		regAddr = 8'h00;
		regWriteData = 8'h00;
		regWrite = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1 regAddr = a;
		regWriteData = d;
		regWrite = 1'b1;
		@(posedge sys_clk);
		#1 regWrite = 1'b0;
		// Stale data inverted so a late sample cannot pass
		regWriteData = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#1 regAddr = a;
		@(posedge sys_clk);
		#1 d = regReadData;
	endtask : rd
endmodule : host_model

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
	import sensor_regs_pkg::*;
	// Arbitrary identity values
	localparam logic [11:0] CT = 12'h9c4;
	localparam logic [3:0]  MR = 4'h6;
	logic           sys_clk = 1'b0;
	logic           reset   = 1'b1;
	logic [3:0]     ev      = 4'h0;
	logic [5:0]     lt      = 6'h00;
	logic [7:0]     regAddr, regWriteData, regReadData, rv, v;
	logic           regWrite, autoExposureEnable, autoGainEnable, busWidthFour;
	logic           extraBlackLines, columnShuffle, sixtyHzTiming, qualifyingClock, frameStrobe;
	exposure_step_t exposureStep;
	logic [1:0]     pinPrev;
	int             n_mismatch = 0;
	int             num_checks = 0;
	int             cyc        = 0;
	wire [7:0]      outs = {exposureStep, sixtyHzTiming, columnShuffle, extraBlackLines,
		busWidthFour, autoGainEnable, autoExposureEnable};
	always #50 sys_clk = ~sys_clk;
	// Line timing stand-ins, each at its own rate
	always @(posedge sys_clk) begin
		#1 lt = lt + 6'h01;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			complete_run();
		end
	end
	sensor_status_setup_registers #(.CHIP_TYPE(CT), .MASK_REVISION(MR)) dut (
		.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
		.regWrite(regWrite), .regReadData(regReadData), .exposureWritten(ev[0]),
		.gainWritten(ev[1]), .exposureConsumed(ev[2]), .gainConsumed(ev[3]),
		.controlPeriod(lt[3]), .dataPeriod(lt[2]), .statusLineVisible(lt[4]),
		.syncOutPulse(lt[5]), .converterComparatorOut(lt[1]),
		.autoExposureEnable(autoExposureEnable), .autoGainEnable(autoGainEnable),
		.busWidthFour(busWidthFour), .extraBlackLines(extraBlackLines),
		.columnShuffle(columnShuffle), .sixtyHzTiming(sixtyHzTiming),
		.exposureStep(exposureStep), .qualifyingClock(qualifyingClock),
		.frameStrobe(frameStrobe));
	host_model host (.sys_clk(sys_clk), .regAddr(regAddr), .regWriteData(regWriteData),
		.regWrite(regWrite), .regReadData(regReadData));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk8
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, rv);
		chk8(rv, e);
	endtask : rc
	task automatic pulse(input logic [3:0] e);
		@(posedge sys_clk);
		#1 ev = e;
		@(posedge sys_clk);
		#1 ev = 4'h0;
	endtask : pulse
	initial begin
		repeat (5) @(posedge sys_clk);
		#1 reset = 1'b0;
		chk8(outs, 8'h67);
		rc(8'h00, {CT[3:0], MR});
		rc(8'h01, CT[11:4]);
		rc(8'h02, 8'h00);
		rc(8'h10, 8'h27);
		rc(8'h11, 8'h70);
		rc(8'h14, 8'h00);
		rc(8'h13, 8'h2f);
		rc(8'h05, 8'h00);
		chk8(outs, 8'h67);
		$display("reset test done");
		for (int i = 0; i < 3; i++)
			host.wr(8'(i), 8'hff);
		rc(8'h00, {CT[3:0], MR});
		rc(8'h01, CT[11:4]);
		rc(8'h02, 8'h00);
		$display("read-only test done");
		host.wr(8'h10, 8'hda);
		host.wr(8'h11, 8'h05);
		rc(8'h10, 8'hda);
		rc(8'h11, 8'h05);
		chk8(outs, 8'h58);
		for (int i = 0; i < 4; i++) begin
			host.wr(8'h13, {1'b1, i[1:0], 5'h0a});
			rc(8'h13, {1'b1, i[1:0], 5'h0a});
			chk8(outs, {i[1:0], 6'h18});
		end
		$display("setup test done");
		rc(8'h02, 8'h00);
		pulse(4'h1);
		rc(8'h02, 8'h01);
		pulse(4'h2);
		rc(8'h02, 8'h05);
		pulse(4'h4);
		rc(8'h02, 8'h04);
		pulse(4'ha);
		rc(8'h02, 8'h04);
		pulse(4'h8);
		rc(8'h02, 8'h00);
		$display("status test done");
		for (int i = 0; i < 8; i++) begin
			v = {i[1:0], 2'b00, i[1:0], i[2] ? i[1:0] : 2'b00};
			host.wr(8'h14, v);
			rc(8'h14, v);
			repeat (6) @(posedge sys_clk);
			#2 pinPrev = {qualifyingClock, frameStrobe};
			@(posedge sys_clk);
			#2;
			if (i[1:0] == 2'b00)
				chk8({6'h00, qualifyingClock, frameStrobe}, 8'h00);
			if (i[1:0] == 2'b01)
				chk8({7'h00, qualifyingClock ^ pinPrev[1]}, 8'h01);
			if (i[2] && i[1])
				chk8({7'h00, frameStrobe ^ pinPrev[0]}, 8'h01);
		end
		$display("pin test done");
		complete_run();
	end
endmodule : tb
